// ---- dfms_checker.sv ----
// Concurrent checks on the ports of the filter mode select block
`default_nettype none
module dfms_checker (
   input wire logic                   clk,
   input wire logic                   rst,
   input wire logic [7:0]             avs_address,
   input wire logic                   avs_read,
   input wire logic                   avs_write,
   input wire logic [31:0]            avs_writedata,
   input wire logic [3:0]             avs_byteenable,
   input wire logic [31:0]            avs_readdata,
   input wire logic                   avs_waitrequest,
   input wire logic                   sampleStrobe,
   input wire logic                   running,
   input var  dfms_pkg::dfms_osr_t    activeOsr,
   input var  dfms_pkg::dfms_filter_t activeType,
   input wire logic                   activeSinc3,
   input wire logic                   activeProgCoef
);
   timeunit 1ns;
   timeprecision 1ps;
   logic ctrlDone;
   logic startSeen;
   assign ctrlDone  = avs_write && !avs_waitrequest && avs_byteenable[0] && avs_address == 8'h80;
   assign startSeen = ctrlDone && avs_writedata[0];
   // Request seen while waitrequest is high, then exactly one cycle with waitrequest low
   sequence s_answer;
      ##1 !avs_waitrequest ##1 avs_waitrequest;
   endsequence
   sequence s_start;
      startSeen ##2 running;
   endsequence
   AST_ANSWER: assert property (@(posedge clk) disable iff (rst)
      (avs_read || avs_write) && avs_waitrequest |-> s_answer) else $error("bus answer timing wrong");
   AST_NO_SPURIOUS: assert property (@(posedge clk) disable iff (rst)
      !avs_waitrequest |-> $past(avs_read || avs_write)) else $error("waitrequest low without request");
   AST_UNMAPPED_ZERO: assert property (@(posedge clk) disable iff (rst) avs_read && !avs_waitrequest &&
      !(avs_address inside {8'h24, 8'h28, 8'h80, 8'h84}) |-> avs_readdata == 32'h0)
      else $error("unmapped read not zero");
   AST_RUN_START: assert property (@(posedge clk) disable iff (rst) startSeen |-> s_start)
      else $error("start not taken");
   AST_RUN_STOP: assert property (@(posedge clk) disable iff (rst) ctrlDone && !avs_writedata[0] |=> !running)
      else $error("stop not taken");
   // Latched setup may only move two edges after a start write
   AST_OSR_HOLD: assert property (@(posedge clk) disable iff (rst) $changed(activeOsr) |-> $past(startSeen, 2))
      else $error("ratio changed without start");
   AST_FLAG_HOLD: assert property (@(posedge clk) disable iff (rst)
      $changed({activeType, activeSinc3, activeProgCoef}) |-> $past(startSeen, 2)) else $error("type changed");
   AST_WB_NO_SINC3: assert property (@(posedge clk) disable iff (rst)
      activeType == dfms_pkg::DFMS_WIDEBAND |-> !activeSinc3) else $error("sinc3 flag in wideband");
   AST_SINC_NO_PROG: assert property (@(posedge clk) disable iff (rst)
      activeType != dfms_pkg::DFMS_WIDEBAND |-> !activeProgCoef) else $error("coefficient flag in sinc");
   AST_STROBE_PULSE: assert property (@(posedge clk) disable iff (rst) sampleStrobe |=> !sampleStrobe)
      else $error("strobe longer than one cycle");
   AST_STROBE_RUN: assert property (@(posedge clk) disable iff (rst) sampleStrobe |-> $past(running))
      else $error("strobe while stopped");
endmodule
`default_nettype wire

// ---- dfms_filter_mode_select.sv ----
// Decimation filter mode select: register slave, start-time latch and output sample timing
//
// Summary of operation
// - Stage select decoded per wideband or sinc mode
// - Wideband: 000 preset, 111 programmable coefficients
// - Sinc: 000 sinc4, 001 sinc3 first stage
// - Codes 0-7: wideband, ratio 32 to 4096
// - Each disabled FIR section halves wideband ratio
// - Output rate is modulator rate over ratio
// - Codes 8-13: sinc ratios 12 to 128
// - Codes 14-23: sinc ratios, mid-speed alternates
// - Codes 24-27: sinc only, long ratios
// - Codes 28-31: sinc plus sinc1 averaging
// - Mode register resets to zero
// - Divide by 2 or 16 forces mid-speed ratios
// - Modulator rate is half the clock
// - Speed field code 01 means mid-speed
// - Separate bits disable second and third FIR
//
// The Avalon-MM slave port was decided locally.
`default_nettype none
`include "dfms_params.svh"
module dfms_filter_mode_select (
   input  wire logic                   clk,
   input  wire logic                   rst,
   input  wire logic [7:0]             avs_address,
   input  wire logic                   avs_read,
   input  wire logic                   avs_write,
   input  wire logic [31:0]            avs_writedata,
   input  wire logic [3:0]             avs_byteenable,
   output logic [31:0]                 avs_readdata,
   output logic                        avs_waitrequest,
   output logic                        sampleStrobe,
   output logic                        running,
   output var  dfms_pkg::dfms_osr_t    activeOsr,
   output var  dfms_pkg::dfms_filter_t activeType,
   output logic                        activeSinc3,
   output logic                        activeProgCoef
);

   // Register storage
   logic [7:0]                filterModeConfig_ff;
   logic [6:0]                filterSectionConfig_ff;
   logic [1:0]                speedMode_ff;
   logic [1:0]                clockDivider_ff;

   // Bus handshake
   logic                      waitRequest_ff;
   logic [31:0]               readData_ff;
   logic [31:0]               nxt_readData;
   logic                      accessFire;
   logic                      writeFire;

   // Start / stop
   logic                      startReq_ff;
   logic                      stopWrite;
   logic                      startWrite;
   dfms_pkg::dfms_state_t     state_ff;
   dfms_pkg::dfms_state_t     nxt_state;

   // Pending decode, from the registers as they stand now
   dfms_pkg::dfms_osr_t       pendOsr;
   dfms_pkg::dfms_filter_t    pendType;
   logic                      pendSinc3;
   logic                      pendProgCoef;
   logic                      pendSelReserved;
   logic                      midAlt;

   // Active configuration, frozen between start writes, even while converting
   dfms_pkg::dfms_osr_t       activeOsr_ff;
   dfms_pkg::dfms_filter_t    activeType_ff;
   logic                      activeSinc3_ff;
   logic                      activeProgCoef_ff;

   // Output timing
   logic                      modPhase_ff;
   logic                      modTick;
   dfms_pkg::dfms_osr_t       ratioCnt_ff;
   logic                      sampleStrobe_ff;

   // Byte address of a register from its index
   function automatic logic regHit(input logic [7:0] addr, input logic [5:0] idx);
      regHit = addr == {idx, 2'b00};
   endfunction

   //------------------------------------------------------------
   // Mid-speed alternates: chosen by speed field or by clock divider
   //------------------------------------------------------------
   assign midAlt = (speedMode_ff == `DFMS_SPEED_MID)
                 || (clockDivider_ff == `DFMS_DIV_BY2)
                 || (clockDivider_ff == `DFMS_DIV_BY16);

   dfms_osr_decode u_decode (
      .filterModeRatio   (filterModeConfig_ff[`DFMS_RATIO_HI:`DFMS_RATIO_LO]),
      .filterStageSelect (filterModeConfig_ff[`DFMS_SEL_HI:`DFMS_SEL_LO]),
      .secondFirDisable  (filterSectionConfig_ff[`DFMS_FIR2_BIT]),
      .thirdFirDisable   (filterSectionConfig_ff[`DFMS_FIR3_BIT]),
      .midAlt            (midAlt),
      .oversamplingRatio (pendOsr),
      .filterType        (pendType),
      .sinc3Stage        (pendSinc3),
      .progCoef          (pendProgCoef),
      .selReserved       (pendSelReserved)
   );

   //------------------------------------------------------------
   // Avalon-MM slave: one wait cycle, then the access completes
   //------------------------------------------------------------
   assign accessFire = (avs_read || avs_write) && !waitRequest_ff;
   assign writeFire = avs_write && !waitRequest_ff && avs_byteenable[0];

   // Drop waitrequest for exactly one cycle per access
   always_ff @(posedge clk) begin
      if (rst) begin
         waitRequest_ff <= 1'b1;
      end else if ((avs_read || avs_write) && waitRequest_ff) begin
         waitRequest_ff <= 1'b0;
      end else begin
         waitRequest_ff <= 1'b1;
      end
   end

   always_comb begin
      nxt_readData = 32'h00000000;
      if (regHit(avs_address, `DFMS_IDX_MODE)) begin
         nxt_readData[7:0] = filterModeConfig_ff;
      end else if (regHit(avs_address, `DFMS_IDX_SECT)) begin
         nxt_readData[`DFMS_SECT_HI:0] = filterSectionConfig_ff;
      end else if (regHit(avs_address, `DFMS_IDX_CTRL)) begin
         nxt_readData[`DFMS_RUN_BIT] = state_ff == dfms_pkg::DFMS_RUN;
         nxt_readData[`DFMS_SPEED_HI:`DFMS_SPEED_LO] = speedMode_ff;
         nxt_readData[`DFMS_CLKDIV_HI:`DFMS_CLKDIV_LO] = clockDivider_ff;
      end else if (regHit(avs_address, `DFMS_IDX_STAT)) begin
         nxt_readData[17:0] = activeOsr_ff;
         nxt_readData[`DFMS_ST_TYPE_LO+1:`DFMS_ST_TYPE_LO] = activeType_ff;
         nxt_readData[`DFMS_ST_SINC3] = activeSinc3_ff;
         nxt_readData[`DFMS_ST_PROG] = activeProgCoef_ff;
         // Flags a reserved stage code sitting in the pending setup
         nxt_readData[`DFMS_ST_RSVD] = pendSelReserved;
         nxt_readData[`DFMS_ST_RUN] = state_ff == dfms_pkg::DFMS_RUN;
      end
   end

   // Data is captured when waitrequest drops and held until the next read
   always_ff @(posedge clk) begin
      if (rst) begin
         readData_ff <= 32'h00000000;
      end else if (avs_read && waitRequest_ff) begin
         readData_ff <= nxt_readData;
      end
   end

   //------------------------------------------------------------
   // Register writes; unmapped addresses are ignored
   //------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         filterModeConfig_ff <= `DFMS_RST_MODE;
      end else if (writeFire && regHit(avs_address, `DFMS_IDX_MODE)) begin
         filterModeConfig_ff <= avs_writedata[7:0];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         filterSectionConfig_ff <= `DFMS_RST_SECT;
      end else if (writeFire && regHit(avs_address, `DFMS_IDX_SECT)) begin
         filterSectionConfig_ff <= avs_writedata[`DFMS_SECT_HI:0];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         speedMode_ff <= `DFMS_RST_SPEED;
         clockDivider_ff <= `DFMS_RST_CLKDIV;
      end else if (writeFire && regHit(avs_address, `DFMS_IDX_CTRL)) begin
         speedMode_ff <= avs_writedata[`DFMS_SPEED_HI:`DFMS_SPEED_LO];
         clockDivider_ff <= avs_writedata[`DFMS_CLKDIV_HI:`DFMS_CLKDIV_LO];
      end
   end

   //------------------------------------------------------------
   // Start and stop of conversions
   //------------------------------------------------------------
   assign startWrite = writeFire && regHit(avs_address, `DFMS_IDX_CTRL) && avs_writedata[`DFMS_RUN_BIT];
   assign stopWrite = writeFire && regHit(avs_address, `DFMS_IDX_CTRL) && !avs_writedata[`DFMS_RUN_BIT];

   // Start is deferred one cycle so a speed or divider change in the same write is seen
   always_ff @(posedge clk) begin
      if (rst) begin
         startReq_ff <= 1'b0;
      end else begin
         startReq_ff <= startWrite;
      end
   end

   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         dfms_pkg::DFMS_IDLE: begin
            if (startReq_ff) begin
               nxt_state = dfms_pkg::DFMS_RUN;
            end
         end
         dfms_pkg::DFMS_RUN: begin
            if (stopWrite) begin
               nxt_state = dfms_pkg::DFMS_IDLE;
            end
         end
         default: begin
            nxt_state = dfms_pkg::DFMS_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state_ff <= dfms_pkg::DFMS_IDLE;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // Configuration is frozen at start so no sample mixes two setups
   always_ff @(posedge clk) begin
      if (rst) begin
         activeOsr_ff <= `DFMS_WB_BASE;
         activeType_ff <= dfms_pkg::DFMS_WIDEBAND;
         activeSinc3_ff <= 1'b0;
         activeProgCoef_ff <= 1'b0;
      end else if (startReq_ff) begin
         activeOsr_ff <= pendOsr;
         activeType_ff <= pendType;
         activeSinc3_ff <= pendSinc3;
         activeProgCoef_ff <= pendProgCoef;
      end
   end

   //------------------------------------------------------------
   // Modulator tick at half the clock, sample every ratio ticks
   //------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         modPhase_ff <= 1'b0;
      end else if (startReq_ff || state_ff != dfms_pkg::DFMS_RUN) begin
         modPhase_ff <= 1'b0;
      end else begin
         modPhase_ff <= ~modPhase_ff;
      end
   end

   assign modTick = modPhase_ff && (state_ff == dfms_pkg::DFMS_RUN) && !startReq_ff;

   // A restart clears the count so the first sample is a full ratio away
   always_ff @(posedge clk) begin
      if (rst) begin
         ratioCnt_ff <= 18'h00000;
      end else if (startReq_ff || state_ff != dfms_pkg::DFMS_RUN) begin
         ratioCnt_ff <= 18'h00000;
      end else if (modTick) begin
         if (ratioCnt_ff == activeOsr_ff - 18'h00001) begin
            ratioCnt_ff <= 18'h00000;
         end else begin
            ratioCnt_ff <= ratioCnt_ff + 18'h00001;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         sampleStrobe_ff <= 1'b0;
      end else begin
         sampleStrobe_ff <= modTick && (ratioCnt_ff == activeOsr_ff - 18'h00001);
      end
   end

   //------------------------------------------------------------
   // Outputs, all from flip-flops
   //------------------------------------------------------------
   assign avs_readdata = readData_ff;
   assign avs_waitrequest = waitRequest_ff;
   assign sampleStrobe = sampleStrobe_ff;
   assign running = state_ff == dfms_pkg::DFMS_RUN;
   assign activeOsr = activeOsr_ff;
   assign activeType = activeType_ff;
   assign activeSinc3 = activeSinc3_ff;
   assign activeProgCoef = activeProgCoef_ff;

endmodule
`default_nettype wire

// ---- dfms_osr_decode.sv ----
// Decode of filter type and effective oversampling ratio from the configuration fields
`default_nettype none
`include "dfms_params.svh"
module dfms_osr_decode (
   input  wire logic [4:0]            filterModeRatio,
   input  wire logic [2:0]            filterStageSelect,
   input  wire logic                  secondFirDisable,
   input  wire logic                  thirdFirDisable,
   input  wire logic                  midAlt,
   output var  dfms_pkg::dfms_osr_t   oversamplingRatio,
   output var  dfms_pkg::dfms_filter_t filterType,
   output logic                       sinc3Stage,
   output logic                       progCoef,
   output logic                       selReserved
);

   logic [3:0] altIdx;
   logic [1:0] cutShift;

   function automatic dfms_pkg::dfms_osr_t fixedRatio(input logic [2:0] idx);
      case (idx)
         3'h0:    fixedRatio = 18'h0000C;
         3'h1:    fixedRatio = 18'h00010;
         3'h2:    fixedRatio = 18'h00018;
         3'h3:    fixedRatio = 18'h00020;
         3'h4:    fixedRatio = 18'h00040;
         default: fixedRatio = 18'h00080;
      endcase
   endfunction

   function automatic dfms_pkg::dfms_osr_t normRatio(input logic [3:0] idx);
      case (idx)
         4'h0:    normRatio = 18'h00100;
         4'h1:    normRatio = 18'h0014D;
         4'h2:    normRatio = 18'h00200;
         4'h3:    normRatio = 18'h0029B;
         4'h4:    normRatio = 18'h00400;
         4'h5:    normRatio = 18'h00535;
         4'h6:    normRatio = 18'h00800;
         4'h7:    normRatio = 18'h00A6B;
         4'h8:    normRatio = 18'h01000;
         default: normRatio = 18'h014D5;
      endcase
   endfunction

   // The averaging stage shifts only the first entry of the long-ratio group
   function automatic dfms_pkg::dfms_osr_t longRatio(input logic [1:0] idx, input logic mid, input logic avg);
      case (idx)
         2'h0:    longRatio = mid ? (avg ? 18'h03416 : 18'h03415) : (avg ? 18'h06820 : 18'h0682B);
         2'h1:    longRatio = mid ? 18'h03E80 : 18'h07D00;
         2'h2:    longRatio = mid ? 18'h0BB80 : 18'h17700;
         default: longRatio = mid ? 18'h13880 : 18'h27100;
      endcase
   endfunction

   assign altIdx = 4'(filterModeRatio - `DFMS_ALT_FIRST);
   // Halve once per disabled FIR section
   assign cutShift = {secondFirDisable & thirdFirDisable, secondFirDisable ^ thirdFirDisable};

   always_comb begin
      oversamplingRatio = `DFMS_WB_BASE;
      filterType = dfms_pkg::DFMS_WIDEBAND;
      sinc3Stage = 1'b0;
      progCoef = 1'b0;
      selReserved = 1'b0;
      // Stage select means different things per filter family
      if (filterModeRatio <= `DFMS_WB_LAST) begin
         oversamplingRatio = (`DFMS_WB_BASE << filterModeRatio[2:0]) >> cutShift;
         progCoef = filterStageSelect == `DFMS_SEL_PROG;
         selReserved = !(filterStageSelect == `DFMS_SEL_PRESET || filterStageSelect == `DFMS_SEL_PROG);
      end else begin
         filterType = (filterModeRatio > `DFMS_SINC_ONLY_LAST) ? dfms_pkg::DFMS_SINC_SINC1 : dfms_pkg::DFMS_SINC;
         sinc3Stage = filterStageSelect == `DFMS_SEL_SINC3;
         selReserved = !(filterStageSelect == `DFMS_SEL_SINC4 || filterStageSelect == `DFMS_SEL_SINC3);
         if (filterModeRatio <= `DFMS_FIXED_LAST) begin
            oversamplingRatio = fixedRatio(filterModeRatio[2:0]);
         end else if (filterModeRatio <= `DFMS_ALT_LAST) begin
            // Mid-speed table is the normal one moved down by one entry
            if (midAlt) begin
               oversamplingRatio = (altIdx == 4'h0) ? `DFMS_MID_FIRST : normRatio(altIdx - 4'h1);
            end else begin
               oversamplingRatio = normRatio(altIdx);
            end
         end else begin
            oversamplingRatio = longRatio(filterModeRatio[1:0], midAlt, filterModeRatio[2]);
         end
      end
   end

endmodule
`default_nettype wire

// ---- dfms_params.svh ----
// Register map, field positions, reset values and code ranges of the filter mode select block
`ifndef DFMS_PARAMS_SVH
`define DFMS_PARAMS_SVH

// Register indices; byte address is four times the index
`define DFMS_IDX_MODE       6'h09
`define DFMS_IDX_SECT       6'h0A
`define DFMS_IDX_CTRL       6'h20
`define DFMS_IDX_STAT       6'h21

// Reset values
`define DFMS_RST_MODE       8'h00
`define DFMS_RST_SECT       7'h01
`define DFMS_RST_SPEED      2'h2
`define DFMS_RST_CLKDIV     2'h0

// filter_mode_config fields
`define DFMS_SEL_HI         7
`define DFMS_SEL_LO         5
`define DFMS_RATIO_HI       4
`define DFMS_RATIO_LO       0

// filter_section_config fields (bit 7 reads zero)
`define DFMS_SECT_HI        6
`define DFMS_FIR2_BIT       2
`define DFMS_FIR3_BIT       1

// Control register fields
`define DFMS_RUN_BIT        0
`define DFMS_SPEED_HI       3
`define DFMS_SPEED_LO       2
`define DFMS_CLKDIV_HI      6
`define DFMS_CLKDIV_LO      5

// Status register fields
`define DFMS_ST_TYPE_LO     18
`define DFMS_ST_SINC3       20
`define DFMS_ST_PROG        21
`define DFMS_ST_RSVD        22
`define DFMS_ST_RUN         31

// Codes
`define DFMS_SPEED_MID      2'h1
`define DFMS_DIV_BY2        2'h1
`define DFMS_DIV_BY16       2'h3
`define DFMS_SEL_PRESET     3'h0
`define DFMS_SEL_PROG       3'h7
`define DFMS_SEL_SINC4      3'h0
`define DFMS_SEL_SINC3      3'h1

// Mode/ratio code ranges
`define DFMS_WB_LAST        5'h07
`define DFMS_FIXED_LAST     5'h0D
`define DFMS_ALT_FIRST      5'h0E
`define DFMS_ALT_LAST       5'h17
`define DFMS_SINC_ONLY_LAST 5'h1B

// Ratio anchors
`define DFMS_WB_BASE        18'h00020
`define DFMS_MID_FIRST      18'h000A7

`endif

// ---- dfms_pkg.sv ----
// Types shared by the filter mode select block
`default_nettype none
package dfms_pkg;
   typedef enum logic [1:0] {
      DFMS_WIDEBAND,
      DFMS_SINC,
      DFMS_SINC_SINC1
   } dfms_filter_t;

   typedef enum logic {
      DFMS_IDLE,
      DFMS_RUN
   } dfms_state_t;

   typedef logic [17:0] dfms_osr_t;
endpackage
`default_nettype wire

// ---- tb.sv ----
// Self-checking bench for the filter mode select block
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic                   clk = 1'b0;
   logic                   rst = 1'b1;
   logic [7:0]             avs_address = 8'h00;
   logic                   avs_read = 1'b0;
   logic                   avs_write = 1'b0;
   logic [31:0]            avs_writedata = 32'h0;
   logic [3:0]             avs_byteenable = 4'h0;
   logic [31:0]            avs_readdata;
   logic                   avs_waitrequest;
   logic                   sampleStrobe;
   logic                   running;
   dfms_pkg::dfms_osr_t    activeOsr;
   dfms_pkg::dfms_filter_t activeType;
   logic                   activeSinc3;
   logic                   activeProgCoef;
   int                     miscompares = 0;
   int                     num_checks = 0;
   dfms_filter_mode_select DUT (.clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .sampleStrobe(sampleStrobe),
      .running(running), .activeOsr(activeOsr), .activeType(activeType), .activeSinc3(activeSinc3),
      .activeProgCoef(activeProgCoef));
   always #12.5 clk = ~clk;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Request held until waitrequest is sampled low; one idle edge keeps drivers single per step
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] be,
                      output logic [31:0] q);
      int n;
      n = 0;
      avs_address <= a;
      avs_writedata <= d;
      avs_byteenable <= be;
      avs_read <= !wr;
      avs_write <= wr;
      do begin
         @(posedge clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      chk(32'(n < 50), 32'h1);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, 4'hF, q);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, 4'hF, q);
      chk(q, e);
   endtask
   task automatic wait_strobe(output int n);
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (sampleStrobe !== 1'b1 && n < 1000);
   endtask
   function automatic logic [31:0] exp_osr(input int code, input bit mid, input int cut);
      int fx[6] = '{12, 16, 24, 32, 64, 128};
      int alt[11] = '{167, 256, 333, 512, 667, 1024, 1333, 2048, 2667, 4096, 5333};
      int lng[8] = '{26667, 32000, 96000, 160000, 26656, 32000, 96000, 160000};
      if (code < 8) return 32'((32 << code) >> cut);
      if (code < 14) return 32'(fx[code - 8]);
      if (code < 24) return 32'(alt[code - 14 + (mid ? 0 : 1)]);
      if (!mid) return 32'(lng[code - 24]);
      return (code == 28) ? 32'd13334 : 32'(lng[code - 24] / 2);
   endfunction
   function automatic logic [31:0] exp_type(input int code);
      return (code < 8) ? 32'h0 : ((code < 28) ? 32'h1 : 32'h2);
   endfunction
   task automatic test_reset;
      chk(32'(activeOsr), 32'h20);
      rdc(8'h24, 32'h00);
      rdc(8'h28, 32'h01);
      rdc(8'h80, 32'h08);
      rdc(8'h84, 32'h20);
      wr(8'h40, 32'hFF);
      rdc(8'h40, 32'h0);
      $display("test reset done");
   endtask
   task automatic test_decode;
      // First three keep the normal ratios: high, max with divide by 8, low; the rest force mid-speed
      logic [7:0] cfg[6] = '{8'h09, 8'h4D, 8'h01, 8'h05, 8'h29, 8'h69};
      for (int c = 0; c < 6; c++) begin
         for (int m = 0; m < 32; m++) begin
            wr(8'h24, 32'(m));
            wr(8'h80, 32'(cfg[c]));
            rdc(8'h84, 32'h80000000 | (exp_type(m) << 18) | exp_osr(m, c > 2, 0));
         end
      end
      $display("test decode done");
   endtask
   task automatic test_stage;
      logic [7:0] md[5] = '{8'hE3, 8'h28, 8'hE8, 8'h08, 8'h43};
      logic [31:0] st[5] = '{32'h80200100, 32'h8014000C, 32'h8044000C, 32'h8004000C, 32'h80400100};
      for (int i = 0; i < 5; i++) begin
         wr(8'h24, 32'(md[i]));
         wr(8'h80, 32'h09);
         rdc(8'h24, 32'(md[i]));
         rdc(8'h84, st[i]);
         chk(32'({activeProgCoef, activeSinc3, activeType}), 32'(st[i][21:18]));
      end
      $display("test stage done");
   endtask
   task automatic test_fir;
      logic [31:0] q;
      wr(8'h24, 32'h07);
      for (int i = 1; i < 4; i++) begin
         wr(8'h28, 32'h01 | 32'(i << 1));
         wr(8'h80, 32'h09);
         rdc(8'h84, 32'h80000000 | exp_osr(7, 0, (i == 3) ? 2 : 1));
      end
      wr(8'h28, 32'hFF);
      rdc(8'h28, 32'h7F);
      wr(8'h28, 32'h01);
      bus(1'b1, 8'h28, 32'h07, 4'h0, q);
      rdc(8'h28, 32'h01);
      $display("test fir done");
   endtask
   task automatic test_timing;
      int n;
      wr(8'h24, 32'h08);
      wr(8'h80, 32'h09);
      // Counting starts at the latch edge, so the first strobe lands one edge past the period
      wait_strobe(n);
      chk(32'(n), 32'd25);
      wait_strobe(n);
      chk(32'(n), 32'd24);
      wr(8'h24, 32'h0D);
      chk(32'(activeOsr), 32'd12);
      wait_strobe(n);
      wait_strobe(n);
      chk(32'(n), 32'd24);
      wr(8'h80, 32'h09);
      // Latched ratio is read once settled, not in the step of its own launching edge
      wait_strobe(n);
      chk(32'(n), 32'd257);
      chk(32'(activeOsr), 32'd128);
      wr(8'h80, 32'h08);
      chk(32'(running), 32'h0);
      wait_strobe(n);
      chk(32'(n), 32'd1000);
      $display("test timing done");
   endtask
   task automatic complete_run;
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   initial begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      test_reset();
      test_decode();
      test_stage();
      test_fir();
      test_timing();
      complete_run();
   end
   // Whole sequence needs under ten thousand cycles
   initial begin
      #(25 * 30000);
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, 32'h0, 32'h1);
      complete_run();
   end
endmodule
bind dfms_filter_mode_select dfms_checker u_chk (.clk(clk), .rst(rst), .avs_address(avs_address),
   .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .sampleStrobe(sampleStrobe),
   .running(running), .activeOsr(activeOsr), .activeType(activeType), .activeSinc3(activeSinc3),
   .activeProgCoef(activeProgCoef));
`default_nettype wire
